// ==== hdl/sdmr_cmd_decode.v ====
`timescale 1ns/10ps
`include "sdmr_defs.vh"
// ---------------------------------------------------------------
// Mode register set command decoder
// ---------------------------------------------------------------
module sdmr_cmd_decode (
   // Command pins, already synchronised
   input  wire       cs_n,
   input  wire       ras_n,
   input  wire       cas_n,
   input  wire       we_n,
   input  wire [2:0] ba,
   // Decode result
   output wire       mrs,
   output wire [3:0] sel
);
   assign mrs    = ~cs_n & ~ras_n & ~cas_n & ~we_n;
   assign sel[0] = mrs & (ba == `SDMR_SEL_MR0); // [R23]
   assign sel[1] = mrs & (ba == `SDMR_SEL_MR1); // [R10]
   assign sel[2] = mrs & (ba == `SDMR_SEL_MR2); // [R19]
   assign sel[3] = mrs & (ba == `SDMR_SEL_MR3); // [R22]
endmodule // sdmr_cmd_decode

// ==== hdl/sdmr_defs.vh ====
`ifndef SDMR_DEFS_VH
`define SDMR_DEFS_VH

// Register selects (bank address)
`define SDMR_SEL_MR0          3'h0
`define SDMR_SEL_MR1          3'h1
`define SDMR_SEL_MR2          3'h2
`define SDMR_SEL_MR3          3'h3
`define SDMR_REG_W            14
`define SDMR_REG_RST          14'h0000

// Register zero fields
`define SDMR_R0_BL_LO         0
`define SDMR_R0_BL_HI         1
`define SDMR_R0_CL_B0         2
`define SDMR_R0_BT            3
`define SDMR_R0_CL_LO         4
`define SDMR_R0_CL_HI         6
`define SDMR_R0_TM            7
`define SDMR_R0_DLLRST        8
`define SDMR_R0_WR_LO         9
`define SDMR_R0_WR_HI         11
`define SDMR_R0_PPD           12

// Burst length encodings
`define SDMR_BL_FIX8          2'h0
`define SDMR_BL_OTF           2'h1
`define SDMR_BL_FIX4          2'h2

// Register one fields
`define SDMR_R1_DLLDIS        0
`define SDMR_R1_DIC0          1
`define SDMR_R1_RTT0          2
`define SDMR_R1_AL_LO         3
`define SDMR_R1_AL_HI         4
`define SDMR_R1_DIC1          5
`define SDMR_R1_RTT1          6
`define SDMR_R1_WLVL          7
`define SDMR_R1_RTT2          9
`define SDMR_R1_TERMINATION_STROBE          11
`define SDMR_R1_QOFF          12

// Register two fields
`define SDMR_R2_CWL_LO        3
`define SDMR_R2_CWL_HI        5
`define SDMR_R2_RTW_LO        9
`define SDMR_R2_RTW_HI        10

// Register three fields
`define SDMR_R3_MPL_LO        0
`define SDMR_R3_MPL_HI        1
`define SDMR_R3_MPR           2

// Latency bases and chop-four pull-in, in clocks
`define SDMR_CL_BASE          5'h04
`define SDMR_CWL_BASE         5'h05
`define SDMR_CHOP_PULL        5'h02

`endif

// ==== hdl/sdmr_mode_regs.v ====
`timescale 1ns/10ps
`include "sdmr_defs.vh"
// Overview of operation
// [R1] Fixed chop-four pulls internal write start, recovery and turnaround in two clocks.
// [R2] Per-command burst length keeps internal write start as an eight-beat write.
// [R3] Read CAS latency from A2,A4-A6; read latency is additive plus CAS.
// [R4] Controller keeps the test-mode bit zero; set means nothing is guaranteed.
// [R5] DLL reset bit clears itself after the DLL reset has been issued.
// [R6] Controller waits DLL lock time after reset before reads or synchronous termination.
// [R7] Controller holds clock enable high throughout the DLL lock interval.
// [R8] Recovery field A9-A11 sets auto-precharge delay with precharge time.
// [R9] A12 clear freezes DLL in precharge power-down; set keeps it running.
// [R10] Strobes low, bank zero high, banks one and two low select register one.
// [R11] Controller writes zero to every reserved bit on each set command; t_mr2_mr3 issues one with bank address 7, bank bit two high.
// [R12] Write leveling limits nominal termination unless output disable is set.
// [R13] Enabled DLL turns off at self-refresh entry and back on at exit.
// [R14] Controller disables termination and dynamic termination while the DLL is off.
// [R15] Output driver impedance comes from register one bits A1 and A5.
// [R16] Reads and writes after activate are held for additive latency internally.
// [R17] Register one A12 set disconnects all data and strobe drivers.
// [R18] Termination strobe enabled gives termination only and ignores data mask.
// [R19] Strobes low, bank one high, banks zero and two low select register two.
// [R20] Write CAS latency from A3-A5; write latency is additive plus write CAS.
// [R21] Dynamic write termination applies during writes, but not in write leveling.
// [R22] Banks zero and one high select register three; A1:A0 ignored when readout off.
// [R23] All strobes and bank bits low select register zero.
// [R24] Burst length from A0-A1 and burst ordering type from A3.
// [R25] Each set command replaces the whole addressed register, others untouched.
module sdmr_mode_regs (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Command and address pins
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [2:0]  ba,
   input  wire [13:0] addr,
   // Device state inputs
   input  wire        sref_active,
   input  wire        ppd_active,
   input  wire        wr_active,
   input  wire        odt_pin,
   // Burst and ordering
   output reg  [1:0]  burst_len_sel,
   output reg         burst_interleave,
   output reg         write_pull_in,
   output reg  [4:0]  write_pull_clocks,
   // Latencies, in clocks
   output reg  [4:0]  cas_latency,
   output reg  [4:0]  additive_latency,
   output reg  [4:0]  read_latency,
   output reg  [4:0]  cas_write_latency,
   output reg  [4:0]  write_latency,
   output reg  [4:0]  cmd_hold_clocks,
   output reg  [4:0]  ap_recovery_clocks,
   // DLL control
   output reg         dll_reset_pulse,
   output reg         dll_run,
   output reg         test_mode,
   // Output drive and termination
   output reg  [1:0]  drive_impedance,
   output reg         outputs_off,
   output reg         write_leveling,
   output reg  [2:0]  rtt_nom_sel,
   output reg  [2:0]  rtt_active_sel,
   output reg         termination_strobe,
   output reg         data_mask_enable,
   // Multipurpose readout
   output reg         multipurpose_readout,
   output reg  [1:0]  readout_location
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg  [24:0] sync1_q;
   reg  [24:0] sync2_q;
   wire [24:0] pins = {cs_n, ras_n, cas_n, we_n, ba, addr,
                       sref_active, ppd_active, wr_active, odt_pin};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 25'h1e00000;
         sync2_q <= 25'h1e00000;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   wire        s_cs_n  = sync2_q[24];
   wire        s_ras_n = sync2_q[23];
   wire        s_cas_n = sync2_q[22];
   wire        s_we_n  = sync2_q[21];
   wire [2:0]  s_ba    = sync2_q[20:18];
   wire [13:0] s_addr  = sync2_q[17:4];
   wire        s_sref  = sync2_q[3];
   wire        s_ppd   = sync2_q[2];
   wire        s_wr    = sync2_q[1];
   wire        s_odt   = sync2_q[0];

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   wire       mrs;
   wire [3:0] sel;

   sdmr_cmd_decode u_dec (
      .cs_n  (s_cs_n),
      .ras_n (s_ras_n),
      .cas_n (s_cas_n),
      .we_n  (s_we_n),
      .ba    (s_ba),
      .mrs   (mrs),
      .sel   (sel)
   );

   // ------------------------------------------------------------
   // Mode registers
   // ------------------------------------------------------------
   // Contents are undefined until software loads them; zero here
   // only gives simulation a known start.
   reg [13:0] mr0_q;
   reg [13:0] mr1_q;
   reg [13:0] mr2_q;
   reg [13:0] mr3_q;
   reg        dll_rst_d;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mr0_q <= `SDMR_REG_RST;
         mr1_q <= `SDMR_REG_RST;
         mr2_q <= `SDMR_REG_RST;
         mr3_q <= `SDMR_REG_RST;
      end else begin
         if (sel[0])
            mr0_q <= s_addr; // [R25]
         else if (mr0_q[`SDMR_R0_DLLRST])
            mr0_q[`SDMR_R0_DLLRST] <= 1'b0; // [R5]
         if (sel[1])
            mr1_q <= s_addr; // [R25]
         if (sel[2])
            mr2_q <= s_addr; // [R25]
         if (sel[3])
            mr3_q <= s_addr; // [R25]
      end
   end

   // DLL reset is issued the cycle after the bit is loaded
   always @* begin
      dll_rst_d = mr0_q[`SDMR_R0_DLLRST];
   end

   // ------------------------------------------------------------
   // Field decode helpers
   // ------------------------------------------------------------
   function [4:0] cl_dec;
      input [3:0] code;
      begin
         cl_dec = `SDMR_CL_BASE + {1'b0, code}; // [R3]
      end
   endfunction

   function [4:0] al_dec;
      input [1:0] code;
      input [4:0] cl;
      begin
         case (code)
            2'h1:    al_dec = cl - 5'h01;
            2'h2:    al_dec = cl - 5'h02;
            default: al_dec = 5'h00;
         endcase
      end
   endfunction

   function [4:0] wr_dec;
      input [2:0] code;
      begin
         case (code)
            3'h0:    wr_dec = 5'h10;
            3'h1:    wr_dec = 5'h05;
            3'h2:    wr_dec = 5'h06;
            3'h3:    wr_dec = 5'h07;
            3'h4:    wr_dec = 5'h08;
            3'h5:    wr_dec = 5'h0a;
            3'h6:    wr_dec = 5'h0c;
            default: wr_dec = 5'h0e;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Applied fields
   // ------------------------------------------------------------
   wire [1:0] bl_q   = mr0_q[`SDMR_R0_BL_HI:`SDMR_R0_BL_LO];
   wire [3:0] cl_cd  = {mr0_q[`SDMR_R0_CL_HI:`SDMR_R0_CL_LO],
                        mr0_q[`SDMR_R0_CL_B0]};
   wire [4:0] cl_v   = cl_dec(cl_cd);
   wire [4:0] al_v   = al_dec(mr1_q[`SDMR_R1_AL_HI:`SDMR_R1_AL_LO],
                              cl_v);
   wire [4:0] cwl_v  = `SDMR_CWL_BASE +
                       {2'h0, mr2_q[`SDMR_R2_CWL_HI:`SDMR_R2_CWL_LO]};
   wire       dll_en = ~mr1_q[`SDMR_R1_DLLDIS];
   wire       wlvl   = mr1_q[`SDMR_R1_WLVL];
   wire [2:0] rtt_n  = {mr1_q[`SDMR_R1_RTT2], mr1_q[`SDMR_R1_RTT1],
                        mr1_q[`SDMR_R1_RTT0]};
   wire [1:0] rtt_w  = mr2_q[`SDMR_R2_RTW_HI:`SDMR_R2_RTW_LO];
   wire       pull   = (bl_q == `SDMR_BL_FIX4); // [R1] [R2]

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_len_sel        <= 2'h0;
         burst_interleave     <= 1'b0;
         write_pull_in        <= 1'b0;
         write_pull_clocks    <= 5'h00;
         cas_latency          <= 5'h00;
         additive_latency     <= 5'h00;
         read_latency         <= 5'h00;
         cas_write_latency    <= 5'h00;
         write_latency        <= 5'h00;
         cmd_hold_clocks      <= 5'h00;
         ap_recovery_clocks   <= 5'h00;
         dll_reset_pulse      <= 1'b0;
         dll_run              <= 1'b0;
         test_mode            <= 1'b0;
         drive_impedance      <= 2'h0;
         outputs_off          <= 1'b0;
         write_leveling       <= 1'b0;
         rtt_nom_sel          <= 3'h0;
         rtt_active_sel       <= 3'h0;
         termination_strobe   <= 1'b0;
         data_mask_enable     <= 1'b1;
         multipurpose_readout <= 1'b0;
         readout_location     <= 2'h0;
      end else begin
         burst_len_sel     <= bl_q; // [R24]
         burst_interleave  <= mr0_q[`SDMR_R0_BT]; // [R24]
         write_pull_in     <= pull; // [R1]
         write_pull_clocks <= pull ? `SDMR_CHOP_PULL : 5'h00; // [R2]
         cas_latency       <= cl_v; // [R3]
         additive_latency  <= al_v;
         read_latency      <= al_v + cl_v; // [R3]
         cas_write_latency <= cwl_v; // [R20]
         write_latency     <= al_v + cwl_v; // [R20]
         cmd_hold_clocks   <= al_v; // [R16]
         ap_recovery_clocks <=
            wr_dec(mr0_q[`SDMR_R0_WR_HI:`SDMR_R0_WR_LO]); // [R8]
         dll_reset_pulse   <= dll_rst_d; // [R5]
         test_mode         <= mr0_q[`SDMR_R0_TM];
         // DLL stops in self-refresh, and in slow-exit power-down
         dll_run <= dll_en & ~s_sref // [R13]
                    & ~(s_ppd & ~mr0_q[`SDMR_R0_PPD]); // [R9]
         drive_impedance   <= {mr1_q[`SDMR_R1_DIC1],
                               mr1_q[`SDMR_R1_DIC0]}; // [R15]
         outputs_off       <= mr1_q[`SDMR_R1_QOFF]; // [R17]
         write_leveling    <= wlvl;
         rtt_nom_sel       <= rtt_n;
         // Termination: dynamic value during writes unless leveling
         if (!s_odt)
            rtt_active_sel <= 3'h0;
         else if (s_wr && !wlvl && rtt_w != 2'h0)
            rtt_active_sel <= {1'b1, rtt_w}; // [R21]
         else
            rtt_active_sel <= rtt_n;
         termination_strobe <= mr1_q[`SDMR_R1_TERMINATION_STROBE]; // [R18]
         data_mask_enable   <= ~mr1_q[`SDMR_R1_TERMINATION_STROBE]; // [R18]
         multipurpose_readout <= mr3_q[`SDMR_R3_MPR];
         readout_location <= mr3_q[`SDMR_R3_MPR] ?
            mr3_q[`SDMR_R3_MPL_HI:`SDMR_R3_MPL_LO] : 2'h0; // [R22]
      end
   end
endmodule // sdmr_mode_regs

// ==== verif/sdmr_ctrl_model.sv ====
`timescale 1ns/10ps
module sdmr_ctrl_model (
   // Clock
   input  wire        clk,
   // Command pins
   output reg         cs_n,
   output reg         ras_n,
   output reg         cas_n,
   output reg         we_n,
   output reg  [2:0]  ba,
   output reg  [13:0] addr
);
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      ba = 3'h0;
      addr = 14'h0000;
   end
   // One-cycle set command; callers pass zero in reserved and test bits, except one call with bank address 7
   // Only set commands are issued: no reads, no clock-enable drop, and
   // the DLL is never disabled in register one, so termination stays legal
   task mrs(input [2:0] b, input [13:0] a);
      begin
         @(negedge clk);
         {cs_n, ras_n, cas_n, we_n} = 4'h0;
         ba = b;
         addr = a;
         @(negedge clk);
         {cs_n, ras_n, cas_n, we_n} = 4'hf;
         // Released lines flip so a stale value never passes as valid
         ba = ~b;
         addr = ~a;
      end
   endtask
endmodule // sdmr_ctrl_model

// ==== verif/sdmr_props.sv ====
`timescale 1ns/10ps
module sdmr_props (
   // Clock, reset and command pins
   input wire        clk,
   input wire        rst_n,
   input wire        cs_n,
   input wire        ras_n,
   input wire        cas_n,
   input wire        we_n,
   input wire [2:0]  ba,
   input wire [13:0] addr,
   // Decoded settings
   input wire [1:0]  burst_len_sel,
   input wire        write_pull_in,
   input wire [4:0]  write_pull_clocks,
   input wire [4:0]  cas_latency,
   input wire [4:0]  additive_latency,
   input wire [4:0]  read_latency,
   input wire [4:0]  cas_write_latency,
   input wire [4:0]  write_latency,
   input wire [4:0]  cmd_hold_clocks,
   input wire        dll_reset_pulse,
   input wire        test_mode,
   input wire [1:0]  drive_impedance,
   input wire        termination_strobe,
   input wire        data_mask_enable,
   input wire        multipurpose_readout,
   input wire [1:0]  readout_location
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire mrs = !cs_n && !ras_n && !cas_n && !we_n;

   pull_in_a:
      assert property (write_pull_in |-> write_pull_clocks == 5'h02)
      else $error("chop-four pull-in is not two clocks");
   on_the_fly_a:
      assert property (burst_len_sel == 2'h1 |-> !write_pull_in)
      else $error("per-command burst pulls write in");
   read_lat_a:
      assert property (read_latency == additive_latency + cas_latency)
      else $error("read latency is not additive plus cas");
   write_lat_a:
      assert property (write_latency == additive_latency + cas_write_latency)
      else $error("write latency is not additive plus write cas");
   cmd_hold_a:
      assert property (cmd_hold_clocks == additive_latency)
      else $error("command hold differs from additive latency");
   dll_pulse_a:
      assert property (mrs && ba == 3'h0 && addr[8] |->
         ##4 dll_reset_pulse ##1 !dll_reset_pulse)
      else $error("dll reset pulse missing or stuck");
   reg_zero_a:
      assert property (mrs && ba == 3'h0 |-> ##5
         test_mode == $past(addr[7], 5) && burst_len_sel == $past(addr[1:0], 5))
      else $error("register zero fields not applied");
   reg_one_a:
      assert property (mrs && ba == 3'h1 |-> ##5
         drive_impedance == {$past(addr[5], 5), $past(addr[1], 5)})
      else $error("drive impedance not taken from register one");
   reg_two_a:
      assert property (mrs && ba == 3'h2 |-> ##5
         cas_write_latency == 5'h05 + $past(addr[5:3], 5))
      else $error("write cas latency not taken from register two");
   mask_strobe_a:
      assert property (data_mask_enable == !termination_strobe)
      else $error("data mask and termination strobe both active");
   readout_a:
      assert property (!multipurpose_readout |-> readout_location == 2'h0)
      else $error("readout location set while readout is off");

   cover property (write_pull_in);
   cover property (dll_reset_pulse);
   cover property (multipurpose_readout && readout_location == 2'h3);
endmodule // sdmr_props

bind sdmr_mode_regs sdmr_props u_props (.clk, .rst_n, .cs_n, .ras_n,
   .cas_n, .we_n, .ba, .addr, .burst_len_sel, .write_pull_in,
   .write_pull_clocks, .cas_latency, .additive_latency, .read_latency,
   .cas_write_latency, .write_latency, .cmd_hold_clocks, .dll_reset_pulse,
   .test_mode, .drive_impedance, .termination_strobe, .data_mask_enable,
   .multipurpose_readout, .readout_location);

// ==== verif/sdram_mode_register_config_tb.sv ====
`timescale 1ns/10ps
module sdram_mode_register_config_tb;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         sref_active = 1'b0;
   reg         ppd_active = 1'b0;
   reg         wr_active = 1'b0;
   reg         odt_pin = 1'b0;
   wire        cs_n, ras_n, cas_n, we_n;
   wire [2:0]  ba, rtt_nom_sel, rtt_active_sel;
   wire [13:0] addr;
   wire [1:0]  burst_len_sel, drive_impedance, readout_location;
   wire [4:0]  write_pull_clocks, cas_latency, additive_latency;
   wire [4:0]  read_latency, cas_write_latency, write_latency;
   wire [4:0]  cmd_hold_clocks, ap_recovery_clocks;
   wire        burst_interleave, write_pull_in, dll_reset_pulse, dll_run;
   wire        test_mode, outputs_off, write_leveling, termination_strobe;
   wire        data_mask_enable, multipurpose_readout;
   integer     mismatches = 0;
   integer     num_checks = 0;
   integer     cycles = 0;
   integer     i;
   integer     n;
   localparam [39:0] wr_tab = {5'h0e, 5'h0c, 5'h0a, 5'h08,
                               5'h07, 5'h06, 5'h05, 5'h10};

   sdmr_mode_regs dut (.clk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .ba,
      .addr, .sref_active, .ppd_active, .wr_active, .odt_pin,
      .burst_len_sel, .burst_interleave, .write_pull_in, .write_pull_clocks,
      .cas_latency, .additive_latency, .read_latency, .cas_write_latency,
      .write_latency, .cmd_hold_clocks, .ap_recovery_clocks,
      .dll_reset_pulse, .dll_run, .test_mode, .drive_impedance,
      .outputs_off, .write_leveling, .rtt_nom_sel, .rtt_active_sel,
      .termination_strobe, .data_mask_enable, .multipurpose_readout,
      .readout_location);
   sdmr_ctrl_model ctl (.clk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         mismatches = mismatches + 1;
         results;
      end
   end

   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // Settings land three edges after the command edge
   task cmd(input [2:0] b, input [13:0] a);
      begin
         ctl.mrs(b, a);
         repeat (4) @(negedge clk);
      end
   endtask
   task wait_state;
      repeat (4) @(negedge clk);
   endtask

   task t_mr0_codes;
      reg [2:0] c;
      reg [1:0] bl;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            c = i;
            bl = i % 3;
            cmd(3'h0, {2'h0, c, 3'h0, c[2], c[1], c[0], c[0], bl});
            chk(burst_len_sel, bl);
            chk(burst_interleave, c[0]);
            chk(write_pull_in, bl == 2'h2);
            chk(write_pull_clocks, bl == 2'h2 ? 5'h02 : 5'h00);
            chk(cas_latency, 5'h04 + c);
            chk(test_mode, 1'b0);
            chk(ap_recovery_clocks, wr_tab[c * 5 +: 5]);
         end
      end
   endtask
   task t_dll_reset;
      begin
         ctl.mrs(3'h0, 14'h0100);
         n = 0;
         repeat (6) begin
            @(negedge clk);
            n = n + dll_reset_pulse;
         end
         chk(n, 1);
      end
   endtask
   task t_mr1;
      begin
         cmd(3'h1, 14'h1a0e);
         chk(drive_impedance, 2'h1);
         chk(outputs_off, 1'b1);
         chk({termination_strobe, data_mask_enable}, 2'h2);
         chk(additive_latency, 5'h03);
         chk(read_latency, 5'h07);
         chk(cmd_hold_clocks, 5'h03);
         chk(rtt_nom_sel, 3'h5);
         chk(cas_latency, 5'h04);
         chk(dll_run, 1'b1);
      end
   endtask
   task t_dll_states;
      begin
         sref_active = 1'b1;
         wait_state;
         chk(dll_run, 1'b0);
         sref_active = 1'b0;
         ppd_active = 1'b1;
         wait_state;
         chk(dll_run, 1'b0);
         cmd(3'h0, 14'h1000);
         chk(dll_run, 1'b1);
         ppd_active = 1'b0;
      end
   endtask
   task t_mr2_mr3;
      begin
         odt_pin = 1'b1;
         wr_active = 1'b1;
         cmd(3'h2, 14'h0418);
         chk(write_latency, 5'h0b);
         chk(rtt_active_sel, 3'h6);
         cmd(3'h1, 14'h1a8e);
         chk(rtt_active_sel, 3'h5);
         chk(write_leveling, 1'b1);
         odt_pin = 1'b0;
         cmd(3'h3, 14'h0007);
         chk({multipurpose_readout, readout_location}, 3'h7);
         cmd(3'h3, 14'h0003);
         chk({multipurpose_readout, readout_location}, 3'h0);
         cmd(3'h7, 14'h0004);
         chk(multipurpose_readout, 1'b0);
         chk(cas_write_latency, 5'h08);
      end
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      chk(data_mask_enable, 1'b1);
      t_mr0_codes;
      t_dll_reset;
      t_mr1;
      t_dll_states;
      t_mr2_mr3;
      results;
   end
endmodule // sdram_mode_register_config_tb
